// ### rtl/pai_pkg.sv
// Purpose: shared constants and types for the port control block
// Assumes: 10 MHz core clock
// Notes: register word is 16 bits, address field 5 bits
package pai_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int HW_RESET_MIN_NS = 1000;
  // least time, rounded up
  localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_RESET_NS = 1000;
  // nominal time, rounded down, at least one cycle
  localparam int SW_RESET_CYC = (SW_RESET_NS / CLK_PERIOD_NS < 1) ? 1 :
                                SW_RESET_NS / CLK_PERIOD_NS;
  // two sync stages plus one spare before straps are taken
  localparam int STRAP_SETTLE_CYC = 3;
  localparam int REG_AW = 5;
  localparam int REG_DW = 16;
  localparam logic [4:0] BASIC_MODE_CONTROL_OFF = 5'h00;
  localparam logic [4:0] PORT_CONFIG_OFF = 5'h19;
  localparam logic [4:0] PORT_CONFIG_TWO_OFF = 5'h1c;
  localparam int BMC_RESET_BIT = 15;
  localparam int BMC_ISOLATE_BIT = 10;
  localparam int BMC_DUPLEX_BIT = 8;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_ADDR_MSB = 4;
  localparam int CFG2_SOFT_RESET_BIT = 9;
  localparam logic [15:0] BASIC_MODE_CONTROL_RST = 16'h0000;
  localparam logic [15:0] PORT_CONFIG_RST = 16'h0000;
  localparam logic [15:0] PORT_CONFIG_TWO_RST = 16'h0000;
  typedef enum logic [3:0] {
    SEQ_RUN = 4'b0001,
    SEQ_HW = 4'b0010,
    SEQ_SW = 4'b0100,
    SEQ_LATCH = 4'b1000
  } pai_seq_state_type;
endpackage

// ### rtl/pai_ctl_if.sv
// Purpose: control signals between core, reset sequencer and link logic
// Assumes: all signals are levels or pulses of the core clock
// Notes: the link side resynchronises what it reads
`timescale 1ns/1ps
`default_nettype none
interface pai_ctl_if;
  logic isolate;     // mii isolate level
  logic full_duplex; // resolved duplex level
  logic dp_reset;    // hold transmit/receive logic in reset
  logic strap_hold;  // straps being sampled, rx pins released
  logic sw_start;    // one-cycle start of full software reset
  logic sw_busy;     // software reset running
  logic regs_clear;  // registers forced to defaults
  logic latch_now;   // one-cycle strap capture
  modport core(output isolate, full_duplex, dp_reset, sw_start,
               input sw_busy, regs_clear, latch_now, strap_hold);
  modport seq(input sw_start, output sw_busy, regs_clear, latch_now, strap_hold);
  modport link(input isolate, full_duplex, dp_reset, strap_hold);
endinterface
`default_nettype wire

// ### rtl/pai_reset_seq.sv
// Purpose: power-on, reset pin and full software reset sequencing
// Assumes: reset pin is asynchronous, filtered here
// Notes: a short pin glitch below the least width is ignored
`timescale 1ns/1ps
`default_nettype none
module pai_reset_seq #(
  parameter int HW_MIN_CYC = pai_pkg::HW_RESET_MIN_CYC,
  parameter int SW_CYC = pai_pkg::SW_RESET_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic reset_n_pin,
  pai_ctl_if.seq ctl
);
  import pai_pkg::*;
  initial begin
    if (HW_MIN_CYC < 1 || HW_MIN_CYC > 255 || SW_CYC < 1 || SW_CYC > 255)
      $error("pai_reset_seq: counts out of range");
  end
  localparam logic [7:0] HW_LAST = 8'(HW_MIN_CYC);
  localparam logic [7:0] SW_LAST = 8'(SW_CYC - 1);
  localparam logic [7:0] SETTLE_LAST = 8'(STRAP_SETTLE_CYC - 1);
  typedef struct packed {
    logic pin_s1;             // first sync stage
    logic pin_s2;             // second sync stage
    logic [7:0] low_cnt;      // cycles the pin has been low
    logic [7:0] cnt;          // software reset / settle timer
    pai_seq_state_type state; // sequence state
  } pai_seq_reg_type;
  pai_seq_reg_type st_q, st_d;
  logic low_hit;
  // pin held low long enough to count as a hardware reset
  assign low_hit = (st_q.low_cnt == HW_LAST);
  assign ctl.sw_busy = (st_q.state == SEQ_SW);
  assign ctl.strap_hold = (st_q.state == SEQ_HW) || (st_q.state == SEQ_LATCH);
  assign ctl.regs_clear = (st_q.state != SEQ_RUN);
  assign ctl.latch_now = (st_q.state == SEQ_LATCH) && (st_q.cnt == SETTLE_LAST);
  // next state
  always_comb begin
    st_d = st_q;
    st_d.pin_s1 = reset_n_pin;
    st_d.pin_s2 = st_q.pin_s1;
    st_d.cnt = st_q.cnt + 8'h01;
    // saturating low-time filter
    if (st_q.pin_s2) begin
      st_d.low_cnt = 8'h00;
    end else if (!low_hit) begin
      st_d.low_cnt = st_q.low_cnt + 8'h01;
    end
    case (st_q.state)
      SEQ_RUN: begin
        if (low_hit) begin
          st_d.state = SEQ_HW;
        end else if (ctl.sw_start) begin
          st_d.state = SEQ_SW;
          st_d.cnt = 8'h00;
        end
      end
      SEQ_SW: begin
        // hardware reset overrides a running software reset
        if (low_hit) begin
          st_d.state = SEQ_HW;
        end else if (st_q.cnt == SW_LAST) begin
          st_d.state = SEQ_RUN;
        end
      end
      SEQ_HW: begin
        st_d.cnt = 8'h00;
        if (st_q.pin_s2) begin
          st_d.state = SEQ_LATCH; // re-latch straps on release
        end
      end
      SEQ_LATCH: begin
        if (low_hit) begin
          st_d.state = SEQ_HW;
        end else if (st_q.cnt == SETTLE_LAST) begin
          st_d.state = SEQ_RUN;
        end
      end
      default: st_d.state = SEQ_LATCH;
    endcase
  end
  // power-on reset starts with a strap latch
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '{pin_s1: 1'b1, pin_s2: 1'b1, low_cnt: 8'h00, cnt: 8'h00,
                state: SEQ_LATCH};
    end else begin
      st_q <= st_d;
    end
  end
  hw_filter_a: assert property (@(posedge clk) disable iff (reset)
    $rose(st_q.state == SEQ_HW) |-> $past(!st_q.pin_s2, 1) && $past(!st_q.pin_s2, 2))
    else $error("hardware reset entered without low pin");
  sw_length_a: assert property (@(posedge clk) disable iff (reset)
    $rose(ctl.sw_busy) |-> (ctl.sw_busy[*8] ##1 ctl.sw_busy[*2] ##1 !ctl.sw_busy)
      or (##[1:10] ctl.strap_hold))
    else $error("software reset length wrong");
endmodule
`default_nettype wire

// ### rtl/pai_mii_link.sv
// Purpose: link-clock side of the mii: carrier, collision, isolate
// Assumes: link_clk runs free; mac transmit inputs are on link_clk
// Notes: control levels arrive from the core clock and are resynced
`timescale 1ns/1ps
`default_nettype none
module pai_mii_link (
  input wire logic link_clk,
  pai_ctl_if.link ctl,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic rx_carrier,
  input wire logic rx_dv_in,
  input wire logic rx_er_in,
  input wire logic [3:0] rxd_in,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [3:0] mii_rxd,
  output logic mii_crs,
  output logic mii_col,
  output logic mii_out_oe,
  output logic mii_clk_oe
);
  typedef struct packed {
    logic [3:0] s1;  // first sync stages: dp, iso, fd, hold
    logic [3:0] s2;  // second sync stages
    logic rx_dv;
    logic rx_er;
    logic [3:0] rxd;
    logic crs;
    logic col;
    logic oe;
    logic line_en;
    logic [3:0] line_txd;
  } pai_link_reg_type;
  pai_link_reg_type st_q, st_d;
  logic dp_s, iso_s, fd_s, hold_s;
  assign dp_s = st_q.s2[3];
  assign iso_s = st_q.s2[2];
  assign fd_s = st_q.s2[1];
  assign hold_s = st_q.s2[0];
  // resync, then compute mii outputs
  always_comb begin
    st_d = st_q;
    st_d.s1 = {ctl.dp_reset, ctl.isolate, ctl.full_duplex, ctl.strap_hold};
    st_d.s2 = st_q.s1;
    // same mii data path in both duplex modes
    st_d.rx_dv = rx_dv_in;
    st_d.rx_er = rx_er_in;
    st_d.rxd = rxd_in;
    // full duplex: carrier from receive only, no collisions
    st_d.crs = fd_s ? rx_carrier : (rx_carrier | tx_en);
    st_d.col = !fd_s && tx_en && rx_carrier;
    // isolate floats the mii and strap sampling releases rx pins
    st_d.oe = !iso_s && !hold_s;
    // isolate ignores mac data; the line keeps sending idles
    st_d.line_en = tx_en && !iso_s;
    // no nibble reaches the line unless the mac is transmitting
    st_d.line_txd = st_d.line_en ? txd : 4'h0;
    if (dp_s) begin
      // soft reset clears transmit and receive state
      st_d.rx_dv = 1'b0;
      st_d.rx_er = 1'b0;
      st_d.rxd = 4'h0;
      st_d.crs = 1'b0;
      st_d.col = 1'b0;
      st_d.oe = 1'b0;
      st_d.line_en = 1'b0;
      st_d.line_txd = 4'h0;
    end
  end
  // sync stages run freely so the reset level itself can cross
  always_ff @(posedge link_clk) begin
    st_q <= st_d;
  end
  assign line_tx_en = st_q.line_en;
  assign line_txd = st_q.line_txd;
  assign mii_rx_dv = st_q.rx_dv;
  assign mii_rx_er = st_q.rx_er;
  assign mii_rxd = st_q.rxd;
  assign mii_crs = st_q.crs;
  assign mii_col = st_q.col;
  assign mii_out_oe = st_q.oe;
  assign mii_clk_oe = st_q.oe;
  crs_half_a: assert property (@(posedge link_clk) disable iff (dp_s)
    !fd_s && tx_en |=> mii_crs)
    else $error("half duplex carrier missed transmit");
  col_full_a: assert property (@(posedge link_clk) disable iff (dp_s)
    fd_s |=> !mii_col && (mii_crs == $past(rx_carrier)))
    else $error("full duplex collision or carrier wrong");
  iso_float_a: assert property (@(posedge link_clk) disable iff (dp_s)
    iso_s |=> !mii_out_oe && !mii_clk_oe)
    else $error("isolated port still drives mii");
  iso_line_a: assert property (@(posedge link_clk) disable iff (dp_s)
    iso_s |=> !line_tx_en && line_txd == 4'h0)
    else $error("isolated port sent packet data");
endmodule
`default_nettype wire

// ### rtl/pai_port_ctrl.sv
// Purpose: one transceiver port: address straps, isolate, duplex, resets
// Assumes: management frames are decoded outside into a word port
// Notes: strap inputs are the rx pin input sides; sampled only in reset
`timescale 1ns/1ps
`default_nettype none
module pai_port_ctrl #(
  parameter logic PORT_SEL = 1'b0, // 0 for port A, 1 for port B
  parameter int HW_MIN_CYC = pai_pkg::HW_RESET_MIN_CYC,
  parameter int SW_CYC = pai_pkg::SW_RESET_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic reset_n_pin,
  input wire logic port_a_rx_bit0_strap,
  input wire logic port_a_rx_bit1_strap,
  input wire logic port_b_rx_bit0_strap,
  input wire logic port_b_rx_bit1_strap,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pai_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pai_pkg::REG_DW-1:0] reg_wdata,
  output logic [pai_pkg::REG_DW-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic an_done,
  input wire logic an_full_duplex,
  input wire logic pd_done,
  output logic full_duplex,
  output logic link_train_en,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic rx_carrier,
  input wire logic rx_dv_in,
  input wire logic rx_er_in,
  input wire logic [3:0] rxd_in,
  output logic line_tx_en,
  output logic [3:0] line_txd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic [3:0] mii_rxd,
  output logic mii_crs,
  output logic mii_col,
  output logic mii_out_oe,
  output logic mii_clk_oe
);
  import pai_pkg::*;

  // the port bit must be a single bit value
  initial begin
    if (PORT_SEL !== 1'b0 && PORT_SEL !== 1'b1)
      $error("pai_port_ctrl: PORT_SEL must be 0 or 1");
  end

  // register word match, used by read and write decode
  function automatic logic hit(input logic [REG_AW-1:0] a,
                               input logic [REG_AW-1:0] off);
    hit = (a == off);
  endfunction

  // all core-clock state of the port
  typedef struct packed {
    logic [3:0] strap_s1;     // strap first sync stage
    logic [3:0] strap_s2;     // strap second sync stage
    logic [4:0] addr;         // latched management address
    logic [15:0] bmc;         // basic mode control word
    logic [10:0] cfg_hi;      // upper port config bits, plain storage
    logic [15:0] cfg2;        // second port config word
    logic fd;                 // resolved duplex
    logic dpr;                // datapath reset level
    logic [15:0] rdata;       // read answer
    logic rvalid;             // read answer strobe
  } pai_core_reg_type;

  pai_core_reg_type st_q, st_d;
  pai_ctl_if ctl ();
  logic wr_ok;      // write accepted this cycle
  logic [15:0] rd_word; // word selected by the read address

  // writes are dropped while a reset holds the registers at default
  assign wr_ok = reg_wr && !ctl.regs_clear;

  // the reset bit write launches the timed software reset
  assign ctl.sw_start = wr_ok && hit(reg_addr, BASIC_MODE_CONTROL_OFF) &&
                        reg_wdata[BMC_RESET_BIT];

  // isolate is always this channel's own control bit
  assign ctl.isolate = st_q.bmc[BMC_ISOLATE_BIT];
  assign ctl.full_duplex = st_q.fd;
  assign ctl.dp_reset = st_q.dpr;

  // read multiplexer; unmapped words read as zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit(reg_addr, BASIC_MODE_CONTROL_OFF)) begin
      rd_word = st_q.bmc;
    end else if (hit(reg_addr, PORT_CONFIG_OFF)) begin
      rd_word = {st_q.cfg_hi, st_q.addr};
    end else if (hit(reg_addr, PORT_CONFIG_TWO_OFF)) begin
      rd_word = st_q.cfg2;
    end
  end

  // next state of the core
  always_comb begin
    st_d = st_q;
    // straps only ever feed the capture below
    st_d.strap_s1 = {port_b_rx_bit1_strap, port_b_rx_bit0_strap,
                     port_a_rx_bit1_strap, port_a_rx_bit0_strap};
    st_d.strap_s2 = st_q.strap_s1;
    // reads answer in every mode, isolate included
    st_d.rvalid = reg_rd;
    st_d.rdata = reg_rd ? rd_word : 16'h0000;
    if (ctl.regs_clear) begin
      // registers back to defaults during any full reset
      st_d.bmc = BASIC_MODE_CONTROL_RST;
      // reset bit reads one while the reset runs
      st_d.bmc[BMC_RESET_BIT] = ctl.sw_busy;
      st_d.cfg_hi = PORT_CONFIG_RST[15:5];
      st_d.cfg2 = PORT_CONFIG_TWO_RST;
    end else if (wr_ok) begin
      if (hit(reg_addr, BASIC_MODE_CONTROL_OFF)) begin
        st_d.bmc = reg_wdata;
      end else if (hit(reg_addr, PORT_CONFIG_OFF)) begin
        // address field is read-only, set only by strap capture
        st_d.cfg_hi = reg_wdata[15:5];
      end else if (hit(reg_addr, PORT_CONFIG_TWO_OFF)) begin
        st_d.cfg2 = reg_wdata;
      end
    end
    // the last busy cycle still loads a one into the reset bit, so the run
    // state clears it; only a fresh reset write may set it again
    if (!ctl.regs_clear && !ctl.sw_start) begin
      st_d.bmc[BMC_RESET_BIT] = 1'b0;
    end
    // strap capture: four straps high, fixed port bit low
    if (ctl.latch_now) begin
      st_d.addr = {st_q.strap_s2, PORT_SEL};
    end
    // negotiated duplex wins; parallel detect forces half
    if (an_done) begin
      st_d.fd = an_full_duplex;
    end else if (pd_done) begin
      st_d.fd = 1'b0;
    end else begin
      st_d.fd = st_q.bmc[BMC_DUPLEX_BIT];
    end
    // soft reset holds the datapath; registers stay as written
    st_d.dpr = ctl.regs_clear || st_q.cfg2[CFG2_SOFT_RESET_BIT];
  end

  // register the whole core state
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '{strap_s1: 4'h0, strap_s2: 4'h0, addr: 5'h00,
                bmc: BASIC_MODE_CONTROL_RST, cfg_hi: PORT_CONFIG_RST[15:5],
                cfg2: PORT_CONFIG_TWO_RST, fd: 1'b0, dpr: 1'b1,
                rdata: 16'h0000, rvalid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // reset sequencer: power-on, pin and timed software reset
  pai_reset_seq #(
    .HW_MIN_CYC(HW_MIN_CYC),
    .SW_CYC(SW_CYC)
  ) u_seq (
    .clk(clk),
    .reset(reset),
    .reset_n_pin(reset_n_pin),
    .ctl(ctl.seq)
  );

  // link-clock side of the mii
  pai_mii_link u_link (
    .link_clk(link_clk),
    .ctl(ctl.link),
    .tx_en(tx_en),
    .txd(txd),
    .rx_carrier(rx_carrier),
    .rx_dv_in(rx_dv_in),
    .rx_er_in(rx_er_in),
    .rxd_in(rxd_in),
    .line_tx_en(line_tx_en),
    .line_txd(line_txd),
    .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er),
    .mii_rxd(mii_rxd),
    .mii_crs(mii_crs),
    .mii_col(mii_col),
    .mii_out_oe(mii_out_oe),
    .mii_clk_oe(mii_clk_oe)
  );

  assign reg_rdata = st_q.rdata;
  assign reg_rvalid = st_q.rvalid;
  assign full_duplex = st_q.fd;
  // training runs on, isolated or not; only datapath reset stops it
  assign link_train_en = !st_q.dpr;

  addr_port_a: assert property (@(posedge clk) disable iff (reset)
    ctl.latch_now |=> st_q.addr[0] == PORT_SEL)
    else $error("address low bit not the port bit");

  strap_take_a: assert property (@(posedge clk) disable iff (reset)
    ctl.latch_now |=> st_q.addr[4:1] == $past(st_q.strap_s2))
    else $error("strap value not captured");

  strap_keep_a: assert property (@(posedge clk) disable iff (reset)
    ctl.sw_busy |=> $stable(st_q.addr))
    else $error("software reset disturbed address");

  iso_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_ok && hit(reg_addr, BASIC_MODE_CONTROL_OFF) |=>
      ctl.isolate == $past(reg_wdata[BMC_ISOLATE_BIT]) || ctl.regs_clear)
    else $error("isolate bit not followed");

  pd_half_a: assert property (@(posedge clk) disable iff (reset)
    pd_done && !an_done |=> !full_duplex)
    else $error("parallel detect gave full duplex");

  rst_bit_a: assert property (@(posedge clk) disable iff (reset)
    $fell(ctl.sw_busy) |=> !st_q.bmc[BMC_RESET_BIT] ##1 !st_q.bmc[BMC_RESET_BIT]
      || ctl.regs_clear || reg_wr)
    else $error("reset bit did not clear");

  soft_keep_a: assert property (@(posedge clk) disable iff (reset)
    st_q.cfg2[CFG2_SOFT_RESET_BIT] && !reg_wr && !ctl.regs_clear |=>
      ctl.dp_reset && $stable(st_q.bmc))
    else $error("soft reset lost registers or datapath reset");

  read_ans_a: assert property (@(posedge clk) disable iff (reset)
    reg_rd && ctl.isolate |=> reg_rvalid && reg_rdata == $past(rd_word))
    else $error("read not answered while isolated");

  // further checks on register state, duplex choice and the reset sequence
  addr_parity_a: assert property (@(posedge clk) disable iff (reset)
    !ctl.strap_hold |-> st_q.addr[0] == PORT_SEL)
    else $error("address parity differs from port");

  addr_ro_a: assert property (@(posedge clk) disable iff (reset)
    !ctl.latch_now |=> $stable(st_q.addr))
    else $error("address moved outside strap capture");

  sw_start_a: assert property (@(posedge clk) disable iff (reset)
    ctl.sw_start |=> st_q.bmc[BMC_RESET_BIT] && (ctl.sw_busy || ctl.strap_hold))
    else $error("software reset did not start");

  hw_default_a: assert property (@(posedge clk) disable iff (reset)
    ctl.regs_clear && !ctl.sw_busy |=>
      st_q.bmc == BASIC_MODE_CONTROL_RST && st_q.cfg2 == PORT_CONFIG_TWO_RST)
    else $error("registers not at default in reset");

  wr_refuse_a: assert property (@(posedge clk) disable iff (reset)
    reg_wr && ctl.sw_busy |=> st_q.cfg2 == PORT_CONFIG_TWO_RST)
    else $error("write taken during software reset");

  rd_idle_a: assert property (@(posedge clk) disable iff (reset)
    !reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000)
    else $error("read answer without request");

  soft_access_a: assert property (@(posedge clk) disable iff (reset)
    st_q.cfg2[CFG2_SOFT_RESET_BIT] && reg_rd |=> reg_rvalid)
    else $error("register read lost during soft reset");

  an_wins_a: assert property (@(posedge clk) disable iff (reset)
    an_done |=> full_duplex == $past(an_full_duplex))
    else $error("negotiated duplex not taken");

  fd_bit_a: assert property (@(posedge clk) disable iff (reset)
    !an_done && !pd_done |=> full_duplex == $past(st_q.bmc[BMC_DUPLEX_BIT]))
    else $error("duplex bit not followed");

  train_iso_a: assert property (@(posedge clk) disable iff (reset)
    ctl.isolate && !ctl.dp_reset |-> link_train_en)
    else $error("isolate stopped link training");
endmodule
`default_nettype wire

// ### verif/pai_mac_model.sv
// Purpose: mac transmit side seen from the port, on the link clock
// Assumes: send and nib are set by the bench at a falling link edge
// Notes: txd keeps toggling while idle so a stale nibble never looks valid
`timescale 1ns/1ps
`default_nettype none
module pai_mac_model (
  input wire logic link_clk,
  input wire logic send,
  input wire logic [3:0] nib,
  output logic tx_en,
  output logic [3:0] txd
);
  // launch after the falling edge, so the rising sample edge sees settled data
  always @(negedge link_clk) begin
    tx_en <= send;
    // idle nibble changes every cycle, a design that ignores tx_en shows it
    txd <= send ? nib : ~txd;
  end
  // quiet bus at time zero
  initial begin
    tx_en = 1'b0;
    txd = 4'h0;
  end
endmodule
`default_nettype wire

// ### verif/pai_port_ctrl_tb_top.sv
// Purpose: self-checking bench for one transceiver port control block
// Assumes: port A instance, reset counts equal to the package defaults, 64 ns link clock
// Notes: expected values come from a small register and carrier model
`timescale 1ns/1ps
`default_nettype none
module pai_port_ctrl_tb_top;
  import pai_pkg::*;
  localparam int HW_CYC = 10; // pin reset width, same as the package default
  localparam int SW_N = 10; // software reset length, same as the package default
  logic clk, reset, link_clk, reset_n_pin, reg_wr, reg_rd, reg_rvalid;
  logic [3:0] strap, txd, rxd_in, line_txd, mii_rxd, nib;
  logic [4:0] reg_addr, m_addr;
  logic [15:0] reg_wdata, reg_rdata, m_bmc, m_cfg, m_cfg2;
  logic an_done, an_full_duplex, pd_done, full_duplex, link_train_en, exp_fd;
  logic tx_en, rx_carrier, rx_dv_in, rx_er_in, line_tx_en, mii_rx_dv, mii_rx_er;
  logic mii_crs, mii_col, mii_out_oe, mii_clk_oe, send;
  int err_count, checked, cyc, seed;

  pai_port_ctrl #(.PORT_SEL(1'b0), .HW_MIN_CYC(HW_CYC), .SW_CYC(SW_N)) pai_port_ctrl_i (
    .clk(clk), .reset(reset), .link_clk(link_clk), .reset_n_pin(reset_n_pin),
    .port_a_rx_bit0_strap(strap[0]), .port_a_rx_bit1_strap(strap[1]),
    .port_b_rx_bit0_strap(strap[2]), .port_b_rx_bit1_strap(strap[3]),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .an_done(an_done),
    .an_full_duplex(an_full_duplex), .pd_done(pd_done), .full_duplex(full_duplex),
    .link_train_en(link_train_en), .tx_en(tx_en), .txd(txd), .rx_carrier(rx_carrier),
    .rx_dv_in(rx_dv_in), .rx_er_in(rx_er_in), .rxd_in(rxd_in), .line_tx_en(line_tx_en),
    .line_txd(line_txd), .mii_rx_dv(mii_rx_dv), .mii_rx_er(mii_rx_er), .mii_rxd(mii_rxd),
    .mii_crs(mii_crs), .mii_col(mii_col), .mii_out_oe(mii_out_oe), .mii_clk_oe(mii_clk_oe));

  pai_mac_model pai_mac_model_i (.link_clk(link_clk), .send(send), .nib(nib),
    .tx_en(tx_en), .txd(txd));

  // core clock 100 ns; link clock 64 ns with an unrelated phase
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #32 link_clk = ~link_clk;
  end

  // closing report, the only place the run ends
  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the couple of hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(string what, logic exp, logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // read strobe for one cycle; answer stands in the following cycle only
  task automatic rd(logic [4:0] a, logic [15:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk1("reg_rvalid", 1'b1, reg_rvalid);
    chk16("reg_rdata", exp, reg_rdata);
  endtask
  // write strobe for one cycle, and the model follows the register map
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    if (a == BASIC_MODE_CONTROL_OFF) m_bmc = d;
    else if (a == PORT_CONFIG_OFF) m_cfg = {d[15:5], m_addr};
    else if (a == PORT_CONFIG_TWO_OFF) m_cfg2 = d;
  endtask
  task automatic lw(int n);
    repeat (n) @(negedge link_clk);
  endtask

  initial begin
    seed = $urandom(32'h4597ffd8);
    {reset, reset_n_pin, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 23'h0};
    {an_done, an_full_duplex, pd_done, send, nib} = 8'h00;
    {rx_carrier, rx_dv_in, rx_er_in, rxd_in} = 7'h00;
    // one port on this bus, so any strap value is a unique address
    strap = 4'($urandom);
    m_addr = {strap, 1'b0};
    {m_bmc, m_cfg, m_cfg2} = {16'h0, 11'h0, m_addr, 16'h0};
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    rd(PORT_CONFIG_OFF, m_cfg);
    wr(PORT_CONFIG_OFF, 16'hffff);
    rd(PORT_CONFIG_OFF, m_cfg);
    rd(5'h05, 16'h0000);
    // straps move after the latch window and must be ignored
    strap = ~strap;
    repeat (4) @(negedge clk);
    rd(PORT_CONFIG_OFF, m_cfg);
    // full software reset: host keeps off the bus for 3 us
    wr(BASIC_MODE_CONTROL_OFF, 16'h8000);
    repeat (30) @(negedge clk);
    {m_bmc, m_cfg} = {16'h0, 11'h0, m_addr};
    rd(BASIC_MODE_CONTROL_OFF, m_bmc);
    rd(PORT_CONFIG_OFF, m_cfg);
    // pin reset relatches new straps and clears the registers
    wr(PORT_CONFIG_OFF, 16'h5a00);
    strap = 4'($urandom);
    m_addr = {strap, 1'b0};
    reset_n_pin = 1'b0;
    repeat (HW_CYC + 5) @(negedge clk);
    reset_n_pin = 1'b1;
    repeat (10) @(negedge clk);
    m_cfg = {11'h0, m_addr};
    rd(PORT_CONFIG_OFF, m_cfg);
    // every mix of negotiation and parallel detect, with the duplex bit set
    wr(BASIC_MODE_CONTROL_OFF, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      {an_done, an_full_duplex, pd_done} = 3'(i);
      repeat (3) @(negedge clk);
      exp_fd = an_done ? an_full_duplex : (!pd_done && m_bmc[8]);
      chk1("full_duplex", exp_fd, full_duplex);
    end
    {an_done, pd_done} = 2'b00;
    // carrier and collision in both duplex modes, other signals unchanged
    for (int d = 0; d < 2; d++) begin
      wr(BASIC_MODE_CONTROL_OFF, d ? 16'h0100 : 16'h0000);
      for (int j = 0; j < 4; j++) begin
        @(negedge link_clk);
        send <= j[1];
        nib <= 4'($urandom);
        rx_carrier <= j[0];
        rx_dv_in <= j[0];
        rx_er_in <= 1'($urandom);
        rxd_in <= 4'($urandom);
        lw(6);
        chk1("mii_crs", j[0] | (j[1] & !d), mii_crs);
        chk1("mii_col", j[0] & j[1] & !d, mii_col);
        chk16("mii_rxd", 16'(rxd_in), 16'(mii_rxd));
        chk1("mii_rx_er", rx_er_in, mii_rx_er);
        chk1("mii_rx_dv", j[0], mii_rx_dv);
        chk1("line_tx_en", j[1], line_tx_en);
        chk16("line_txd", 16'(j[1] ? nib : 4'h0), 16'(line_txd));
      end
    end
    // isolate: outputs released, transmit ignored, registers still answer
    wr(BASIC_MODE_CONTROL_OFF, 16'h0400);
    lw(6);
    chk1("line_tx_en", 1'b0, line_tx_en);
    chk16("line_txd", 16'h0000, 16'(line_txd));
    chk1("mii_out_oe", 1'b0, mii_out_oe);
    chk1("mii_clk_oe", 1'b0, mii_clk_oe);
    chk1("link_train_en", 1'b1, link_train_en);
    rd(BASIC_MODE_CONTROL_OFF, m_bmc);
    wr(BASIC_MODE_CONTROL_OFF, 16'h0000);
    lw(6);
    chk1("mii_out_oe", 1'b1, mii_out_oe);
    // datapath soft reset keeps the register contents
    wr(PORT_CONFIG_TWO_OFF, 16'h0200);
    lw(6);
    chk1("link_train_en", 1'b0, link_train_en);
    chk1("mii_crs", 1'b0, mii_crs);
    rd(PORT_CONFIG_TWO_OFF, m_cfg2);
    rd(PORT_CONFIG_OFF, m_cfg);
    wr(PORT_CONFIG_TWO_OFF, 16'h0000);
    lw(6);
    chk1("link_train_en", 1'b1, link_train_en);
    results();
  end
endmodule
`default_nettype wire
